/* hdl/gpio_port_pkg.sv */
// constants, register map and state type of the gpio port register bank
package gpio_port_pkg;
    // ==========================================
    // sizes
    localparam int PIN_COUNT = 16;
    localparam int ADDR_W = 12;
    localparam int KEY_BIT = 16;
    // ==========================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PIN_MODE_SELECT = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_DRIVE_TYPE = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_SLEW_SELECT = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_PULL_RESISTOR_SELECT = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_PIN_INPUT_LEVELS = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_PIN_OUTPUT_LEVELS = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_ATOMIC_SET_CLEAR = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_CONFIG_FREEZE = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_ALT_FUNCTION_LOW = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_ALT_FUNCTION_HIGH = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_ATOMIC_CLEAR_ONLY = 12'h028;
    // ==========================================
    // field codes
    localparam logic [1:0] MODE_INPUT = 2'h0;
    localparam logic [1:0] MODE_OUTPUT = 2'h1;
    localparam logic [1:0] MODE_ALT = 2'h2;
    localparam logic [1:0] MODE_ANALOG = 2'h3;
    // ==========================================
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;
    // ==========================================
    // key sequence states
    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'h1,
        SEQ_GOT1  = 4'h2,
        SEQ_GOT0  = 4'h4,
        SEQ_ARMED = 4'h8
    } seq_t;
    // ==========================================
    // whole state of the bank
    typedef struct packed {
        logic [31:0] mode;
        logic [15:0] otype;
        logic [31:0] slew;
        logic [31:0] pull;
        logic [15:0] odata;
        logic [15:0] freeze;
        logic key;
        seq_t seq;
        logic [15:0] seq_mask;
        logic [31:0] afl;
        logic [31:0] afh;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] idata;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;
endpackage

/* hdl/gpio_port_register_bank.sv */
// apb register bank of one 16-pin general-purpose port with configuration lock
module gpio_port_register_bank
    import gpio_port_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pads
    input wire logic [PIN_COUNT-1:0] pin_level_i,
    output logic [PIN_COUNT-1:0] driven_level_o,
    output logic [2*PIN_COUNT-1:0] pin_function_o,
    output logic [PIN_COUNT-1:0] drive_type_o,
    output logic [2*PIN_COUNT-1:0] slew_o,
    output logic [2*PIN_COUNT-1:0] pull_o,
    output logic [4*PIN_COUNT-1:0] alt_selector_o
);
    // ==========================================
    // state
    state_t st_r;
    state_t st_nxt;
    logic [PIN_COUNT-1:0] lk_w;
    logic [2*PIN_COUNT-1:0] lk2_w;
    logic [4*PIN_COUNT-1:0] lk4_w;
    logic [PIN_COUNT-1:0] an_w;
    logic setup_w;
    logic wr_w;
    logic rd_w;
    logic [ADDR_W-1:0] word_w;

    assign setup_w = psel_i & ~penable_i;
    assign wr_w = psel_i & penable_i & st_r.pready & pwrite_i;
    assign rd_w = psel_i & penable_i & st_r.pready & ~pwrite_i;
    assign word_w = {paddr_i[ADDR_W-1:2], 2'h0};
    assign lk_w = st_r.freeze & {PIN_COUNT{st_r.key}};

    // ==========================================
    // per-pin lock masks and analog detect
    genvar g;
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
        assign lk2_w[2*g+1:2*g] = {2{lk_w[g]}};
        assign lk4_w[4*g+3:4*g] = {4{lk_w[g]}};
        assign an_w[g] = (st_r.mode[2*g+1:2*g] == MODE_ANALOG);
    end

    // ==========================================
    // read mux
    function automatic logic [31:0] read_word(input state_t s, input logic [ADDR_W-1:0] a);
        logic [31:0] r;
        r = RST_WORD;
        case (a)
            OFS_PIN_MODE_SELECT: r = s.mode;
            OFS_OUTPUT_DRIVE_TYPE: r = {RST_HALF, s.otype};
            OFS_OUTPUT_SLEW_SELECT: r = s.slew;
            OFS_PULL_RESISTOR_SELECT: r = s.pull;
            OFS_PIN_INPUT_LEVELS: r = {RST_HALF, s.idata};
            OFS_PIN_OUTPUT_LEVELS: r = {RST_HALF, s.odata};
            OFS_CONFIG_FREEZE: r = {15'h0000, s.key, s.freeze};
            OFS_ALT_FUNCTION_LOW: r = s.afl;
            OFS_ALT_FUNCTION_HIGH: r = s.afh;
            default: r = RST_WORD;
        endcase
        return r;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a <= OFS_ATOMIC_CLEAR_ONLY;
    endfunction

    // ==========================================
    // next state
    always_comb begin
        st_nxt = st_r;
        // two-flop synchroniser, then sample; analog pins read zero
        st_nxt.sync1 = pin_level_i;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.idata = st_r.sync2 & ~an_w;
        // apb: zero-wait answer prepared in the setup cycle
        st_nxt.pready = setup_w;
        st_nxt.pslverr = setup_w & ~mapped(word_w);
        // set/clear registers and reserved words read zero
        st_nxt.prdata = setup_w ? read_word(st_r, word_w) : RST_WORD;
        if (wr_w && mapped(word_w)) begin
            case (word_w)
                OFS_PIN_MODE_SELECT: begin
                    st_nxt.mode = (st_r.mode & lk2_w) | (pwdata_i & ~lk2_w);
                end
                OFS_OUTPUT_DRIVE_TYPE: begin
                    st_nxt.otype = (st_r.otype & lk_w) | (pwdata_i[15:0] & ~lk_w);
                end
                OFS_OUTPUT_SLEW_SELECT: begin
                    st_nxt.slew = (st_r.slew & lk2_w) | (pwdata_i & ~lk2_w);
                end
                OFS_PULL_RESISTOR_SELECT: begin
                    st_nxt.pull = (st_r.pull & lk2_w) | (pwdata_i & ~lk2_w);
                end
                OFS_PIN_OUTPUT_LEVELS: begin
                    st_nxt.odata = pwdata_i[15:0];
                end
                OFS_ATOMIC_SET_CLEAR: begin
                    // set applied after clear so it wins
                    st_nxt.odata = (st_r.odata & ~pwdata_i[31:16]) | pwdata_i[15:0];
                end
                OFS_ATOMIC_CLEAR_ONLY: begin
                    st_nxt.odata = st_r.odata & ~pwdata_i[15:0];
                end
                OFS_ALT_FUNCTION_LOW: begin
                    st_nxt.afl = (st_r.afl & lk4_w[31:0]) | (pwdata_i & ~lk4_w[31:0]);
                end
                OFS_ALT_FUNCTION_HIGH: begin
                    st_nxt.afh = (st_r.afh & lk4_w[63:32]) | (pwdata_i & ~lk4_w[63:32]);
                end
                OFS_CONFIG_FREEZE: begin
                    if (!st_r.key) begin
                        st_nxt.freeze = pwdata_i[15:0];
                        case (st_r.seq)
                            SEQ_GOT1: begin
                                if (!pwdata_i[KEY_BIT] && pwdata_i[15:0] == st_r.seq_mask) begin
                                    st_nxt.seq = SEQ_GOT0;
                                end else begin
                                    st_nxt.seq = pwdata_i[KEY_BIT] ? SEQ_GOT1 : SEQ_IDLE;
                                end
                            end
                            SEQ_GOT0: begin
                                if (pwdata_i[KEY_BIT] && pwdata_i[15:0] == st_r.seq_mask) begin
                                    st_nxt.seq = SEQ_ARMED;
                                end else begin
                                    st_nxt.seq = pwdata_i[KEY_BIT] ? SEQ_GOT1 : SEQ_IDLE;
                                end
                            end
                            default: begin
                                st_nxt.seq = pwdata_i[KEY_BIT] ? SEQ_GOT1 : SEQ_IDLE;
                            end
                        endcase
                        if (pwdata_i[KEY_BIT]) begin
                            st_nxt.seq_mask = pwdata_i[15:0];
                        end
                    end
                end
                default: begin
                    // input levels are read-only
                    st_nxt.idata = st_r.sync2 & ~an_w;
                end
            endcase
        end
        // the read that closes the sequence arms the key for good
        if (rd_w && word_w == OFS_CONFIG_FREEZE && !st_r.key) begin
            if (st_r.seq == SEQ_ARMED) begin
                st_nxt.key = 1'b1;
            end
            st_nxt.seq = SEQ_IDLE;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '{mode: RST_WORD, otype: RST_HALF, slew: RST_WORD, pull: RST_WORD,
                      odata: RST_HALF, freeze: RST_HALF, key: 1'b0, seq: SEQ_IDLE,
                      seq_mask: RST_HALF, afl: RST_WORD, afh: RST_WORD, sync1: RST_HALF,
                      sync2: RST_HALF, idata: RST_HALF, prdata: RST_WORD, pready: 1'b0,
                      pslverr: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // outputs
    assign prdata_o = st_r.prdata;
    assign pready_o = st_r.pready;
    assign pslverr_o = st_r.pslverr;
    assign driven_level_o = st_r.odata;
    assign pin_function_o = st_r.mode;
    assign drive_type_o = st_r.otype;
    assign slew_o = st_r.slew;
    assign pull_o = st_r.pull;
    assign alt_selector_o = {st_r.afh, st_r.afl};

    // ==========================================
    // assertions
    a_key_stays_set:
    assert property (@(posedge clock_i) disable iff (!rstn_i) st_r.key |=> st_r.key && $stable(st_r.freeze))
        else $error("key or freeze bits changed after lock");

    a_mode_lock_held:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_PIN_MODE_SELECT |=> ((st_r.mode ^ $past(st_r.mode)) & $past(lk2_w)) == 32'h0)
        else $error("locked mode field changed");

    a_set_beats_clear:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_ATOMIC_SET_CLEAR
        |=> st_r.odata == (($past(st_r.odata) & ~$past(pwdata_i[31:16])) | $past(pwdata_i[15:0])))
        else $error("set/clear result wrong");

    a_clear_only_op:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_ATOMIC_CLEAR_ONLY |=> st_r.odata == ($past(st_r.odata) & ~$past(pwdata_i[15:0])))
        else $error("clear-only result wrong");

    a_sample_levels:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        $past(rstn_i) && $past(rstn_i, 2) && $past(rstn_i, 3)
        |-> st_r.idata == ($past(pin_level_i, 3) & ~$past(an_w)))
        else $error("input level sample wrong");

    a_wo_reads_zero:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        setup_w && !pwrite_i && word_w == OFS_ATOMIC_SET_CLEAR |=> pready_o && prdata_o == 32'h0)
        else $error("write-only register read nonzero");

    a_seq_abort:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_CONFIG_FREEZE && !pwdata_i[KEY_BIT] && st_r.seq != SEQ_GOT1 && !st_r.key
        |=> st_r.seq == SEQ_IDLE ##1 !st_r.key)
        else $error("bad key step did not abort");

    a_key_arms:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        rd_w && word_w == OFS_CONFIG_FREEZE && st_r.seq == SEQ_ARMED |=> st_r.key ##1 st_r.key)
        else $error("key did not arm");

    a_apb_answer:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        setup_w |=> pready_o ##1 !pready_o || setup_w)
        else $error("apb ready timing wrong");

    // ==========================================
    // lock, reset and register map checks
    a_type_lock_held:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_OUTPUT_DRIVE_TYPE
        |=> ((st_r.otype ^ $past(st_r.otype)) & $past(lk_w)) == RST_HALF)
        else $error("locked drive type bit changed");

    a_slew_lock_held:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_OUTPUT_SLEW_SELECT
        |=> ((st_r.slew ^ $past(st_r.slew)) & $past(lk2_w)) == RST_WORD)
        else $error("locked slew field changed");

    a_pull_lock_held:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_PULL_RESISTOR_SELECT
        |=> ((st_r.pull ^ $past(st_r.pull)) & $past(lk2_w)) == RST_WORD)
        else $error("locked pull field changed");

    a_alt_lock_held:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && (word_w == OFS_ALT_FUNCTION_LOW || word_w == OFS_ALT_FUNCTION_HIGH)
        |=> ((alt_selector_o ^ $past(alt_selector_o)) & $past(lk4_w)) == {RST_WORD, RST_WORD})
        else $error("locked alternate selector changed");

    a_type_write_lands:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_OUTPUT_DRIVE_TYPE && !st_r.key
        |=> drive_type_o == $past(pwdata_i[15:0]))
        else $error("drive type write lost");

    a_freeze_write_lands:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_CONFIG_FREEZE && !st_r.key
        |=> st_r.freeze == $past(pwdata_i[15:0]))
        else $error("freeze bits write lost");

    a_freeze_gate:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_CONFIG_FREEZE && st_r.key
        |=> $stable(st_r.freeze) && $stable(st_r.seq))
        else $error("freeze bits written while key active");

    a_input_read_only:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_PIN_INPUT_LEVELS
        |=> $stable(st_r.mode) && $stable(st_r.odata) && $stable(st_r.freeze) && $stable(st_r.seq))
        else $error("write to input levels changed state");

    a_odata_write_lands:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_PIN_OUTPUT_LEVELS
        |=> driven_level_o == $past(pwdata_i[15:0]))
        else $error("output levels write lost");

    a_key_reads_one:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        setup_w && !pwrite_i && word_w == OFS_CONFIG_FREEZE && st_r.key
        |=> pready_o && prdata_o[KEY_BIT])
        else $error("active key read as zero");

    a_clear_reads_zero:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        setup_w && !pwrite_i && word_w == OFS_ATOMIC_CLEAR_ONLY
        |=> pready_o && prdata_o == RST_WORD)
        else $error("clear-only register read nonzero");

    a_reset_state:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        !$past(rstn_i)
        |-> pin_function_o == RST_WORD && drive_type_o == RST_HALF && driven_level_o == RST_HALF && !st_r.key)
        else $error("state after reset not cleared");

    a_key_needs_read:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_w && word_w == OFS_CONFIG_FREEZE && !st_r.key
        |=> !st_r.key)
        else $error("key armed by a write");

    a_analog_reads_zero:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        $past(rstn_i)
        |-> (st_r.idata & $past(an_w)) == RST_HALF)
        else $error("analog pin sampled nonzero");

endmodule // gpio_port_register_bank

/* bench/gpio_pin_model.sv */
// pad model: drives the pin level seen by the port from its outputs and an external level
module gpio_pin_model
    import gpio_port_pkg::*;
(
    // port side
    input wire logic [PIN_COUNT-1:0] driven_level_i,
    input wire logic [2*PIN_COUNT-1:0] pin_function_i,
    input wire logic [PIN_COUNT-1:0] drive_type_i,
    // outside world
    input wire logic [PIN_COUNT-1:0] ext_level_i,
    output logic [PIN_COUNT-1:0] pin_level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // open drain only pulls low; a released line shows the outside level
    always_comb begin
        for (int p = 0; p < PIN_COUNT; p++) begin
            if (pin_function_i[2*p+:2] == MODE_OUTPUT) begin
                pin_level_o[p] = driven_level_i[p] & (drive_type_i[p] ? ext_level_i[p] : 1'b1);
            end else begin
                pin_level_o[p] = ext_level_i[p];
            end
        end
    end
endmodule // gpio_pin_model

/* bench/gpio_port_register_bank_bench.sv */
// self-checking bench of the gpio port register bank against a behavioural model
module gpio_port_register_bank_bench;
    import gpio_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // signals
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [15:0] pin_level, ext = 16'h0000, drv, dtype;
    logic [31:0] func, slew, pull;
    logic [63:0] alt;
    logic [31:0] m [11];
    logic key;
    logic [15:0] smask;
    int seq, n_fail = 0, total_checks = 0;
    always #20 clock_i = ~clock_i;
    gpio_port_register_bank i_gpio_port_register_bank (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pin_level_i(pin_level), .driven_level_o(drv),
        .pin_function_o(func), .drive_type_o(dtype), .slew_o(slew), .pull_o(pull), .alt_selector_o(alt));
    gpio_pin_model i_gpio_pin_model (.driven_level_i(drv), .pin_function_i(func), .drive_type_i(dtype),
        .ext_level_i(ext), .pin_level_o(pin_level));
    // ==========================================
    // reporting
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pads();
        chk("pad modes", m[0], func);
        chk("driven levels", m[5], {16'h0, drv});
        chk("pad drive types", m[1], {16'h0, dtype});
        chk("pad slews", m[2], slew);
        chk("pad pulls", m[3], pull);
        chk("pad alternates low", m[8], alt[31:0]);
        chk("pad alternates high", m[9], alt[63:32]);
    endtask
    // ==========================================
    // model
    function automatic logic [63:0] ex(logic [15:0] k, int w);
        logic [63:0] r;
        r = 64'h0;
        for (int p = 0; p < 16; p++) r[w*p+:4] = {4{k[p]}} & ((4'h1 << w) - 4'h1);
        return r;
    endfunction
    function automatic void mreset();
        foreach (m[i]) m[i] = 32'h0000_0000;
        key = 1'b0;
        seq = 0;
        smask = 16'h0000;
    endfunction
    function automatic void mw(int i, logic [31:0] d);
        logic [15:0] lk;
        logic [63:0] l2, l4;
        lk = key ? m[7][15:0] : 16'h0000;
        l2 = ex(lk, 2);
        l4 = ex(lk, 4);
        case (i)
            0, 2, 3: m[i] = (m[i] & l2[31:0]) | (d & ~l2[31:0]);
            1: m[1] = ((m[1] & {16'h0, lk}) | (d & ~{16'h0, lk})) & 32'h0000_ffff;
            5: m[5] = d & 32'h0000_ffff;
            6: m[5] = ((m[5] & ~(d >> 16)) | d) & 32'h0000_ffff;
            7: if (!key) begin
                m[7] = d & 32'h0000_ffff;
                if (d[16]) begin
                    if (seq == 2 && d[15:0] == smask) seq = 3;
                    else begin seq = 1; smask = d[15:0]; end
                end else seq = (seq == 1 && d[15:0] == smask) ? 2 : 0;
            end
            8: m[8] = (m[8] & l4[31:0]) | (d & ~l4[31:0]);
            9: m[9] = (m[9] & l4[63:32]) | (d & ~l4[63:32]);
            10: m[5] = m[5] & ~d & 32'h0000_ffff;
            default: ;
        endcase
    endfunction
    function automatic logic [31:0] mr(int i);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (i == 4) begin
            for (int p = 0; p < 16; p++) begin
                r[p] = ext[p];
                if (m[0][2*p+:2] == 2'h1) r[p] = m[5][p] & (m[1][p] ? ext[p] : 1'b1);
                if (m[0][2*p+:2] == 2'h3) r[p] = 1'b0;
            end
        end else if (i == 7) begin
            r = {15'h0, key, m[7][15:0]};
            if (seq == 3) key = 1'b1;
            seq = 0;
        end else if (i < 11 && i != 6 && i != 10) r = m[i];
        return r;
    endfunction
    // ==========================================
    // apb master
    task automatic apb(logic w, int i, logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= 12'(i * 4);
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clock_i); n++; end while (pready !== 1'b1 && n < 10);
        if (pready !== 1'b1) begin n_fail++; $display("unexpected pready timeout"); end_of_test(); end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(int i, logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, i, d, q, e);
        chk("write error flag", {31'h0, i > 10}, {31'h0, e});
        mw(i, d);
    endtask
    task automatic rc(int i);
        logic [31:0] q;
        logic e;
        apb(1'b0, i, 32'h0, q, e);
        chk($sformatf("read of word %0d", i), mr(i), q);
        chk("read error flag", {31'h0, i > 10}, {31'h0, e});
    endtask
    task automatic rst();
        rstn_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rstn_i <= 1'b1;
        mreset();
    endtask
    // ==========================================
    // scenarios
    initial begin
        logic [15:0] k;
        void'($urandom(60));
        rst();
        for (int i = 0; i < 12; i++) rc(i);
        pads();
        repeat (4) begin
            for (int i = 0; i < 12; i++) wr(i, $urandom);
            ext <= 16'($urandom);
            repeat (4) @(posedge clock_i);
            for (int i = 0; i < 12; i++) rc(i);
            pads();
        end
        wr(6, 32'hffff_0f0f);
        rc(5);
        k = 16'($urandom);
        wr(7, {15'h0, 1'b1, k});
        wr(7, {15'h0, 1'b0, k ^ 16'h0001});
        wr(7, {15'h0, 1'b1, k});
        rc(7);
        rc(7);
        wr(7, {15'h0, 1'b1, k ^ 16'h0002});
        wr(7, {15'h0, 1'b0, k ^ 16'h0002});
        wr(7, {15'h0, 1'b1, k});
        wr(7, {15'h0, 1'b0, k});
        wr(7, {15'h0, 1'b1, k});
        rc(7);
        rc(7);
        wr(7, 32'h0000_0000);
        rc(7);
        for (int i = 0; i < 11; i++) wr(i, $urandom);
        for (int i = 0; i < 11; i++) rc(i);
        pads();
        rst();
        rc(7);
        wr(0, 32'h5555_aaaa);
        rc(0);
        end_of_test();
    end
endmodule // gpio_port_register_bank_bench
